// ---- hw/rms_pkg.sv ----
// Purpose: shared constants and types for the radio mode sequencer
// Assumes: 50 MHz clock, classic Wishbone register access
// Notes: times are kept in ns and converted to clock cycles here
package rms_pkg;
    localparam int CLK_NS = 20;
    // register byte offsets
    localparam logic [7:0] OFS_OP_MODE = 8'h00;
    localparam logic [7:0] OFS_AMP_RAMP = 8'h04;
    localparam logic [7:0] OFS_TIMING = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    // op mode register fields
    localparam int MODE_LSB = 2;
    localparam int LISTEN_BIT = 6;
    localparam int BYPASS_BIT = 7;
    // timing register fields
    localparam int BITT_LSB = 0;
    localparam int RXBW_LSB = 16;
    localparam int OOK_BIT = 31;
    localparam int CONT_BIT = 30;
    localparam int BSYNC_BIT = 29;
    localparam int PACKET_BIT = 28;
    // operating field codes
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_SYNTH = 3'h2;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_RX = 3'h4;
    // timing constants
    localparam int TX_FIXED_NS = 5000;
    localparam int TX_FIXED_CYC = (TX_FIXED_NS + CLK_NS - 1) / CLK_NS;
    localparam int RX_FRONT_NS = 20000;
    localparam int RX_FRONT_CYC = (RX_FRONT_NS + CLK_NS - 1) / CLK_NS;
    localparam int PLL_BW_KHZ = 300;
    localparam int RELOCK_NS = (5 * 1000000 + PLL_BW_KHZ - 1) / PLL_BW_KHZ;
    localparam int RELOCK_CYC = (RELOCK_NS + CLK_NS - 1) / CLK_NS;
    localparam int FSK_CF_NUM = 21;
    localparam int OOK_CF_NUM = 34;
    localparam int AFC_BITS = 4;
    localparam int PREAMBLE_BITS = 12;
    localparam logic [31:0] RESET_OP_MODE = 32'h0000_0004;
    localparam logic [31:0] RESET_TIMING = 32'h00C8_09C4;
    localparam logic [31:0] RESET_RAMP = 32'h0000_0FA0;
    // enabled sub-block set
    typedef struct packed {
        logic osc;
        logic synth;
        logic ampReg;
        logic ampRamp;
        logic rx;
        logic listen;
    } rms_enables_t;
    typedef enum logic [9:0] {
        ST_SLEEP = 10'b00_0000_0001,
        ST_OSC = 10'b00_0000_0010,
        ST_SYNTH = 10'b00_0000_0100,
        ST_AMPREG = 10'b00_0000_1000,
        ST_RAMP = 10'b00_0001_0000,
        ST_TXDLY = 10'b00_0010_0000,
        ST_TX = 10'b00_0100_0000,
        ST_RXDLY = 10'b00_1000_0000,
        ST_RX = 10'b01_0000_0000,
        ST_LISTEN = 10'b10_0000_0000
    } rms_state_t;
endpackage : rms_pkg

// ---- hw/rms_sequencer.sv ----
// Purpose: operating-mode sequencer of a sub-GHz transceiver
// Assumes: oscillator, synthesizer and amplifier report readiness on inputs
// Notes: listen internals and the packet engine sit outside this block
`timescale 1ns/1ns
`default_nettype none
module rms_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    // analog readiness, asynchronous
    input wire logic oscStable,
    input wire logic synthLock,
    input wire logic ampRegReady,
    input wire logic afcDone,
    input wire logic transmitStartRule,
    // demodulator and host pins
    input wire logic demodData,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe_b,
    output logic dataClockOut,
    output logic pllLockPin,
    // sub-block enables and status
    output rms_pkg::rms_enables_t enables,
    output logic modeReachedFlag,
    output logic transmitReadyFlag,
    output logic receiveReadyFlag,
    output logic preambleOnly,
    output logic packetActive,
    output logic syncAccept
);
    logic [31:0] opMode_q, ramp_q, timing_q;
    rms_pkg::rms_state_t st_q, st_d;
    logic [31:0] cnt_q;
    logic [2:0] targetMode_q;
    logic targetListen_q;
    logic [4:0] s1_q, s2_q;
    logic osc, lock, ampOk, afc, startOk;
    logic [15:0] divCnt_q;
    logic data_clock_output_q;
    logic [7:0] pre_q;
    logic [4:0] preCnt_q;
    logic afcSeen_q;
    logic dinS1_q, dinS2_q, demS1_q, demS2_q;
    logic [2:0] wrMode;
    logic wbHit;

    // byte-lane merge used for every writable register
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : laneMerge

    // ns to cycles, rounded up and never below one
    function automatic logic [31:0] nsToCyc(input logic [31:0] ns);
        logic [31:0] c;
        c = (ns + 32'(rms_pkg::CLK_NS - 1)) / 32'(rms_pkg::CLK_NS);
        return (c == 32'h0) ? 32'h1 : c;
    endfunction : nsToCyc

    // two-flop synchronisers; only the second stage is read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q <= 5'h0;
            s2_q <= 5'h0;
            {dinS1_q, dinS2_q, demS1_q, demS2_q} <= 4'h0;
        end
        else
        begin
            s1_q <= {oscStable, synthLock, ampRegReady, afcDone, transmitStartRule};
            s2_q <= s1_q;
            dinS1_q <= serialDataIn;
            dinS2_q <= dinS1_q;
            demS1_q <= demodData;
            demS2_q <= demS1_q;
        end
    end
    assign {osc, lock, ampOk, afc, startOk} = s2_q;

    assign wbHit = wbCyc && wbStb && !wbAck;
    assign wrMode = opMode_q[rms_pkg::MODE_LSB +: 3];

    // register writes; a write acks one cycle after the request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opMode_q <= rms_pkg::RESET_OP_MODE;
            ramp_q <= rms_pkg::RESET_RAMP;
            timing_q <= rms_pkg::RESET_TIMING;
        end
        else if (wbHit && wbWe)
        begin
            case (wbAdr)
                rms_pkg::OFS_OP_MODE: opMode_q <= laneMerge(opMode_q, wbDatW, wbSel) & 32'h0000_00FC;
                rms_pkg::OFS_AMP_RAMP: ramp_q <= laneMerge(ramp_q, wbDatW, wbSel);
                rms_pkg::OFS_TIMING: timing_q <= laneMerge(timing_q, wbDatW, wbSel);
                default: ;
            endcase
        end
    end

    // ack and read data; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wbAck <= 1'b0;
            wbDatR <= 32'h0;
        end
        else
        begin
            wbAck <= wbHit;
            case (wbAdr)
                rms_pkg::OFS_OP_MODE: wbDatR <= opMode_q;
                rms_pkg::OFS_AMP_RAMP: wbDatR <= ramp_q;
                rms_pkg::OFS_TIMING: wbDatR <= timing_q;
                rms_pkg::OFS_STATUS: wbDatR <= {22'h0, st_q};
                default: wbDatR <= 32'h0;
            endcase
        end
    end

    // next state: walk toward the target, or jump when bypassed
    always_comb
    begin
        st_d = st_q;
        if (opMode_q[rms_pkg::LISTEN_BIT])
            st_d = rms_pkg::ST_LISTEN;
        else if (opMode_q[rms_pkg::BYPASS_BIT])
        begin
            case (wrMode)
                rms_pkg::MODE_STANDBY: st_d = rms_pkg::ST_OSC;
                rms_pkg::MODE_SYNTH: st_d = rms_pkg::ST_SYNTH;
                rms_pkg::MODE_TX: st_d = rms_pkg::ST_TX;
                rms_pkg::MODE_RX: st_d = rms_pkg::ST_RX;
                default: st_d = rms_pkg::ST_SLEEP;
            endcase
        end
        else
        begin
            case (st_q)
                rms_pkg::ST_SLEEP, rms_pkg::ST_LISTEN:
                    if (wrMode != rms_pkg::MODE_SLEEP)
                        st_d = rms_pkg::ST_OSC;
                    else
                        st_d = rms_pkg::ST_SLEEP;
                rms_pkg::ST_OSC:
                    if (wrMode == rms_pkg::MODE_SLEEP)
                        st_d = rms_pkg::ST_SLEEP;
                    else if (wrMode != rms_pkg::MODE_STANDBY && osc)
                        st_d = rms_pkg::ST_SYNTH;
                rms_pkg::ST_SYNTH:
                    if (wrMode == rms_pkg::MODE_SLEEP || wrMode == rms_pkg::MODE_STANDBY)
                        st_d = rms_pkg::ST_OSC;
                    else if (lock && wrMode == rms_pkg::MODE_TX)
                        st_d = rms_pkg::ST_AMPREG;
                    else if (lock && wrMode == rms_pkg::MODE_RX)
                        st_d = rms_pkg::ST_RXDLY;
                rms_pkg::ST_AMPREG:
                    if (wrMode != rms_pkg::MODE_TX)
                        st_d = rms_pkg::ST_SYNTH;
                    else if (ampOk)
                        st_d = rms_pkg::ST_RAMP;
                rms_pkg::ST_RAMP, rms_pkg::ST_TXDLY:
                    if (wrMode != rms_pkg::MODE_TX)
                        st_d = rms_pkg::ST_SYNTH;
                    else if (cnt_q <= 32'h1)
                        st_d = (st_q == rms_pkg::ST_RAMP) ? rms_pkg::ST_TXDLY : rms_pkg::ST_TX;
                rms_pkg::ST_RXDLY:
                    if (wrMode != rms_pkg::MODE_RX)
                        st_d = rms_pkg::ST_SYNTH;
                    else if (cnt_q <= 32'h1)
                        st_d = rms_pkg::ST_RX;
                rms_pkg::ST_TX, rms_pkg::ST_RX:
                    if (st_q == rms_pkg::ST_TX && wrMode == rms_pkg::MODE_RX)
                        st_d = rms_pkg::ST_RXDLY; // hop via receive keeps the loop locked
                    else if (st_q == rms_pkg::ST_RX && wrMode == rms_pkg::MODE_TX)
                        st_d = rms_pkg::ST_AMPREG;
                    else if (wrMode != ((st_q == rms_pkg::ST_TX) ? rms_pkg::MODE_TX : rms_pkg::MODE_RX))
                        st_d = rms_pkg::ST_SYNTH;
                default: st_d = rms_pkg::ST_SLEEP;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= rms_pkg::ST_SLEEP;
        else
            st_q <= st_d;
    end

    // delay counter loads on state entry
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 32'h0;
        else if (st_d != st_q)
        begin
            case (st_d)
                rms_pkg::ST_RAMP: cnt_q <= nsToCyc(ramp_q); // ramp length in ns
                rms_pkg::ST_TXDLY: cnt_q <= 32'(rms_pkg::TX_FIXED_CYC) + (nsToCyc(ramp_q) >> 2)
                    + (timing_q[15:0] >> 1); // ramp already spent once
                rms_pkg::ST_RXDLY: cnt_q <= 32'(rms_pkg::RX_FRONT_CYC) + nsToCyc(
                    ((timing_q[rms_pkg::OOK_BIT] ? 32'(rms_pkg::OOK_CF_NUM) : 32'(rms_pkg::FSK_CF_NUM))
                    * 32'd250000) / ({20'h0, timing_q[rms_pkg::RXBW_LSB +: 12]}
                    | 32'(timing_q[rms_pkg::RXBW_LSB +: 12] == 12'h0))); // zero bandwidth guard
                default: cnt_q <= 32'h0;
            endcase
        end
        else if (afc && !afcSeen_q && st_q == rms_pkg::ST_RX)
            cnt_q <= 32'(rms_pkg::RELOCK_CYC) + 32'(rms_pkg::AFC_BITS) * {16'h0, timing_q[15:0]};
        else if (cnt_q != 32'h0)
            cnt_q <= cnt_q - 32'h1;
    end

    // target capture and correction edge memory
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            targetMode_q <= rms_pkg::MODE_SLEEP;
            targetListen_q <= 1'b0;
            afcSeen_q <= 1'b0;
        end
        else
        begin
            targetMode_q <= wrMode;
            targetListen_q <= opMode_q[rms_pkg::LISTEN_BIT];
            afcSeen_q <= afc;
        end
    end

    // ready flags: clear on any change, set when target reached
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            modeReachedFlag <= 1'b0;
            transmitReadyFlag <= 1'b0;
            receiveReadyFlag <= 1'b0;
        end
        else
        begin
            if (targetMode_q != wrMode || targetListen_q != opMode_q[rms_pkg::LISTEN_BIT] || st_d != st_q)
                modeReachedFlag <= 1'b0;
            else
            begin
                case (st_q)
                    rms_pkg::ST_SLEEP: modeReachedFlag <= wrMode == rms_pkg::MODE_SLEEP;
                    rms_pkg::ST_OSC: modeReachedFlag <= wrMode == rms_pkg::MODE_STANDBY;
                    rms_pkg::ST_SYNTH: modeReachedFlag <= wrMode == rms_pkg::MODE_SYNTH;
                    rms_pkg::ST_TX, rms_pkg::ST_RX, rms_pkg::ST_LISTEN: modeReachedFlag <= 1'b1;
                    default: modeReachedFlag <= 1'b0;
                endcase
            end
            transmitReadyFlag <= st_q == rms_pkg::ST_TX && st_d == st_q;
            receiveReadyFlag <= st_q == rms_pkg::ST_RX && st_d == st_q && cnt_q == 32'h0;
        end
    end

    // data clock runs only in transmit and receive, one edge pair per bit
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divCnt_q <= 16'h0;
            data_clock_output_q <= 1'b0;
        end
        else if (st_q != rms_pkg::ST_TX && st_q != rms_pkg::ST_RX)
        begin
            divCnt_q <= 16'h0; // no clock before ramp done
            data_clock_output_q <= 1'b0;
        end
        else if (divCnt_q + 16'h1 >= (timing_q[15:0] >> 1)) // each level lasts half a bit
        begin
            divCnt_q <= 16'h0;
            data_clock_output_q <= !data_clock_output_q;
        end
        else
            divCnt_q <= divCnt_q + 16'h1;
    end

    // preamble lock: count alternating bits at data clock falling edges
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_q <= 8'h0;
            preCnt_q <= 5'h0;
        end
        else if (st_q != rms_pkg::ST_RX)
        begin
            pre_q <= 8'h0;
            preCnt_q <= 5'h0;
        end
        else if (divCnt_q == 16'h0 && !data_clock_output_q)
        begin
            pre_q <= {pre_q[6:0], demS2_q};
            if (demS2_q == pre_q[0])
                preCnt_q <= 5'h0;
            else if (preCnt_q < 5'(rms_pkg::PREAMBLE_BITS))
                preCnt_q <= preCnt_q + 5'h1;
        end
    end

    // pins and transmit data control
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serialDataOut <= 1'b0;
            pllLockPin <= 1'b0;
            packetActive <= 1'b0;
        end
        else
        begin
            serialDataOut <= demS2_q;
            pllLockPin <= lock;
            packetActive <= st_q == rms_pkg::ST_TX && timing_q[rms_pkg::PACKET_BIT]
                && (packetActive || startOk);
        end
    end

    assign serialDataOe_b = !(st_q == rms_pkg::ST_RX && timing_q[rms_pkg::CONT_BIT]);
    assign dataClockOut = data_clock_output_q;
    assign preambleOnly = transmitReadyFlag && timing_q[rms_pkg::PACKET_BIT] && !packetActive;
    assign syncAccept = receiveReadyFlag && (preCnt_q >= 5'(rms_pkg::PREAMBLE_BITS)
        || (timing_q[rms_pkg::CONT_BIT] && !timing_q[rms_pkg::BSYNC_BIT]));

    // sub-block enables follow the state
    always_comb
    begin
        enables = '0;
        enables.osc = st_q != rms_pkg::ST_SLEEP;
        enables.synth = st_q inside {rms_pkg::ST_SYNTH, rms_pkg::ST_AMPREG, rms_pkg::ST_RAMP,
            rms_pkg::ST_TXDLY, rms_pkg::ST_TX, rms_pkg::ST_RXDLY, rms_pkg::ST_RX};
        enables.ampReg = st_q inside {rms_pkg::ST_AMPREG, rms_pkg::ST_RAMP, rms_pkg::ST_TXDLY, rms_pkg::ST_TX};
        enables.ampRamp = st_q inside {rms_pkg::ST_RAMP, rms_pkg::ST_TXDLY, rms_pkg::ST_TX};
        enables.rx = st_q inside {rms_pkg::ST_RXDLY, rms_pkg::ST_RX};
        enables.listen = st_q == rms_pkg::ST_LISTEN;
    end
endmodule : rms_sequencer
`default_nettype wire

// ---- bench/rms_sequencer_props.sv ----
// Purpose: concurrent checks on the mode sequencer ports
// Assumes: single 50 MHz domain, async active-low reset
// Notes: bound to every rms_sequencer instance below
`timescale 1ns/1ns
`default_nettype none
module rms_sequencer_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [31:0] wbDatW,
    input wire logic wbAck,
    // readiness and status
    input wire logic synthLock,
    input wire logic pllLockPin,
    input wire logic dataClockOut,
    input wire rms_pkg::rms_enables_t enables,
    input wire logic modeReachedFlag,
    input wire logic transmitReadyFlag,
    input wire logic receiveReadyFlag,
    input wire logic preambleOnly,
    input wire logic packetActive,
    // data path
    input wire logic demodData,
    input wire logic serialDataOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic bypass_q;
    // bypass skips the wake order, so ordering checks must know it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            bypass_q <= 1'b0;
        else if (wbCyc && wbStb && wbAck && wbWe && wbAdr == rms_pkg::OFS_OP_MODE)
            bypass_q <= wbDatW[rms_pkg::BYPASS_BIT];
    end
    // op mode write as the slave takes it
    sequence modeWrite;
        wbCyc && wbStb && !wbAck && wbWe && wbAdr == rms_pkg::OFS_OP_MODE;
    endsequence
    a_ack_one_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    a_ack_answers_req: assert property ((wbCyc && wbStb && !wbAck) |=> wbAck)
        else $error("request not acked next cycle");
    a_tx_after_lock: assert property (($rose(transmitReadyFlag) && !bypass_q) |-> pllLockPin && modeReachedFlag)
        else $error("transmit ready without lock or mode flag");
    a_lock_pin_tracks: assert property (synthLock [*5] |-> pllLockPin)
        else $error("lock pin not following lock");
    a_ramp_after_reg: assert property (($rose(enables.ampRamp) && !bypass_q) |-> $past(enables.ampReg))
        else $error("ramp before regulator");
    a_data_clock_output_gated: assert property (dataClockOut |-> (enables.ampRamp || enables.rx
        || $past(enables.ampRamp || enables.rx)))
        else $error("data clock outside tx or rx");
    a_listen_forced: assert property ((modeWrite ##0 wbDatW[rms_pkg::LISTEN_BIT]) |-> ##[1:8] enables.listen)
        else $error("listen not entered");
    a_sleep_bypass: assert property ((modeWrite ##0 (wbDatW[7:2] == 6'h20)) |-> ##[1:8] (enables == '0))
        else $error("sleep left blocks on");
    a_mode_flag_clears: assert property (modeWrite |-> ##[1:3] !modeReachedFlag)
        else $error("mode flag kept over a mode write");
    a_rx_ready_on: assert property (receiveReadyFlag |-> (enables.rx || $past(enables.rx)))
        else $error("receive ready with receiver off");
    a_preamble_first: assert property (preambleOnly |-> transmitReadyFlag && !packetActive)
        else $error("preamble phase out of place");
    // two sync stages plus the output register
    a_data_passes: assert property (serialDataOut == $past(demodData, 3))
        else $error("data pin not following demodulator");
endmodule : rms_sequencer_props
bind rms_sequencer rms_sequencer_props props_u (.clk, .rst_b, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbDatW,
    .wbAck, .synthLock, .pllLockPin, .dataClockOut, .enables, .modeReachedFlag, .transmitReadyFlag,
    .receiveReadyFlag, .preambleOnly, .packetActive, .demodData, .serialDataOut);
`default_nettype wire

// ---- bench/rms_analog_model.sv ----
// Purpose: stand-in for oscillator, synthesizer, amplifier and demodulator
// Assumes: readiness follows the osc, synth and ampReg enables after DLY cycles
// Notes: demod output churns every cycle while the receiver is off
`timescale 1ns/1ns
`default_nettype none
module rms_analog_model #(
    parameter int DLY = 20,
    parameter int BITCYC = 100
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // sequencer side
    input wire rms_pkg::rms_enables_t enables,
    output logic oscStable,
    output logic synthLock,
    output logic ampRegReady,
    output logic afcDone,
    output logic demodData
);
    int oscCnt, synCnt, ampCnt, bitCnt;
    // ready drops at once when the block is switched off
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oscCnt <= 0;
            synCnt <= 0;
            ampCnt <= 0;
        end
        else
        begin
            oscCnt <= enables.osc ? oscCnt + 1 : 0;
            synCnt <= enables.synth ? synCnt + 1 : 0;
            ampCnt <= enables.ampReg ? ampCnt + 1 : 0;
        end
    end
    assign oscStable = enables.osc && oscCnt >= DLY;
    assign synthLock = enables.synth && synCnt >= DLY;
    assign ampRegReady = enables.ampReg && ampCnt >= DLY;
    assign afcDone = 1'b0;
    // alternating preamble at the bit rate, noise otherwise
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bitCnt <= 0;
            demodData <= 1'b0;
        end
        else
        begin
            bitCnt <= (bitCnt == BITCYC - 1) ? 0 : bitCnt + 1;
            demodData <= (enables.rx && bitCnt != BITCYC - 1) ? demodData : ~demodData;
        end
    end
endmodule : rms_analog_model
`default_nettype wire

// ---- bench/rms_sequencer_test.sv ----
// Purpose: self-checking bench for the mode sequencer
// Assumes: 100-cycle bits, 200 ns ramp, 2100 kHz bandwidth
// Notes: tx and rx start-up windows allow a few sync cycles
`timescale 1ns/1ns
`default_nettype none
module rms_sequencer_test;
    localparam logic [31:0] TIM = (32'h834 << rms_pkg::RXBW_LSB) | 32'h64;
    logic clk, rst_b, wbCyc, wbStb, wbWe, wbAck, oscStable, synthLock, ampRegReady, afcDone;
    logic txRule, hostData, demodData, serialDataOut, serialDataOe_b, dataClockOut, pllLockPin;
    logic modeReachedFlag, transmitReadyFlag, receiveReadyFlag, preambleOnly, packetActive, syncAccept;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR;
    rms_pkg::rms_enables_t enables;
    int bad_count = 0;
    int checks = 0;
    rms_sequencer dut_u (.clk, .rst_b, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck,
        .oscStable, .synthLock, .ampRegReady, .afcDone, .transmitStartRule(txRule), .demodData,
        .serialDataIn(hostData), .serialDataOut, .serialDataOe_b, .dataClockOut, .pllLockPin, .enables,
        .modeReachedFlag, .transmitReadyFlag, .receiveReadyFlag, .preambleOnly, .packetActive, .syncAccept);
    rms_analog_model model_u (.clk, .rst_b, .enables, .oscStable, .synthLock, .ampRegReady, .afcDone,
        .demodData);
    // free-running 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic tally_and_finish();
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask : chk_rng
    // one classic cycle, held until ack is sampled
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= wd;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 50)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wb_io
    function automatic logic flag(input int w);
        case (w)
            1: flag = receiveReadyFlag;
            2: flag = syncAccept;
            3: flag = packetActive;
            5: flag = transmitReadyFlag;
            default: flag = enables.listen;
        endcase
    endfunction : flag
    task automatic wait_flag(input int w, output int n);
        n = 0;
        while (flag(w) !== 1'b1)
        begin
            @(posedge clk);
            n++;
            if (n > 5000)
            begin
                bad_count++;
                tally_and_finish();
            end
        end
    endtask : wait_flag
    task automatic t_reset_regs();
        logic [31:0] rd;
        wb_io(1'b0, rms_pkg::OFS_OP_MODE, 32'h0, rd);
        chk(rd, rms_pkg::RESET_OP_MODE);
        wb_io(1'b0, rms_pkg::OFS_AMP_RAMP, 32'h0, rd);
        chk(rd, rms_pkg::RESET_RAMP);
        wb_io(1'b0, rms_pkg::OFS_TIMING, 32'h0, rd);
        chk(rd, rms_pkg::RESET_TIMING);
        wb_io(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        wb_io(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0);
    endtask : t_reset_regs
    task automatic t_tx();
        logic [31:0] rd;
        int n, tR;
        wb_io(1'b1, rms_pkg::OFS_AMP_RAMP, 32'hC8, rd);
        wb_io(1'b1, rms_pkg::OFS_TIMING, TIM | (32'h1 << rms_pkg::PACKET_BIT), rd);
        wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'h80, rd);
        repeat (8) @(posedge clk);
        chk(32'(enables), 32'h0);
        wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'hC, rd);
        n = 0;
        tR = -1;
        // amplifier may only wake after lock; time from ramp start to transmit ready
        while (transmitReadyFlag !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            n++;
            if (enables.ampReg === 1'b1)
                chk(32'(pllLockPin), 32'h1);
            if (enables.ampRamp === 1'b1 && tR < 0)
                tR = n;
        end
        if (n >= 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
        chk_rng(n - tR, 311, 318);
        chk(32'(modeReachedFlag), 32'h1);
        chk(32'(preambleOnly), 32'h1);
        txRule <= 1'b1;
        wait_flag(3, n);
        chk(32'(preambleOnly), 32'h0);
    endtask : t_tx
    task automatic t_rx();
        logic [31:0] rd;
        int n;
        wb_io(1'b1, rms_pkg::OFS_TIMING, TIM | (32'h3 << rms_pkg::BSYNC_BIT), rd);
        wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'h10, rd);
        wait_flag(1, n);
        chk_rng(n, 1125, 1145);
        chk(32'(syncAccept), 32'h0);
        wait_flag(2, n);
        chk_rng(n, 1000, 2500);
        wb_io(1'b1, rms_pkg::OFS_TIMING, TIM | (32'h3 << rms_pkg::CONT_BIT), rd);
        repeat (4) @(posedge clk);
        chk(32'(syncAccept), 32'h1);
        chk(32'(serialDataOe_b), 32'h0);
        // receiver hop, now with the OOK filter delay
        wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'h8, rd);
        wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'h10, rd);
        wait_flag(1, n);
        chk_rng(n, 1203, 1215);
        // transmitter hop back out of receive
        wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'hC, rd);
        wait_flag(5, n);
        chk(32'(modeReachedFlag), 32'h1);
        hostData <= 1'b1;
    endtask : t_rx
    task automatic t_bypass();
        logic [31:0] rd;
        logic [5:0] m [5] = '{6'h00, 6'h20, 6'h10, 6'h04, 6'h02};
        int n;
        for (int i = 0; i < 5; i++)
        begin
            wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'h80 | (32'(i) << 2), rd);
            repeat (6) @(posedge clk);
            chk(32'(enables & (i == 0 ? 6'h3F : m[i])), 32'(m[i]));
        end
        wb_io(1'b1, rms_pkg::OFS_OP_MODE, 32'h44, rd);
        wait_flag(4, n);
        wb_io(1'b0, rms_pkg::OFS_STATUS, 32'h0, rd);
        chk(rd, 32'(rms_pkg::ST_LISTEN));
    endtask : t_bypass
    // reset, then each scenario in turn
    initial
    begin
        rst_b = 1'b0;
        {wbCyc, wbStb, wbWe, txRule, hostData} = 5'h0;
        wbAdr = 8'h00;
        wbSel = 4'hF;
        wbDatW = 32'h0;
        repeat (20) @(posedge clk);
        chk(32'(serialDataOe_b), 32'h1);
        rst_b <= 1'b1;
        t_reset_regs();
        t_tx();
        t_rx();
        t_bypass();
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        #2000000;
        bad_count++;
        tally_and_finish();
    end
endmodule : rms_sequencer_test
`default_nettype wire
